// ==== rtl/lcqm_pkg.sv ====
// constants, carriers and state types of the line cycle quality monitor
// assumes a 20 MHz reference clock and register strobes from the serial port engine
package lcqm_pkg;

	// clock and tick rates
	localparam int REF_CLK_HZ   = 20000000;
	localparam int FAST_TICK_HZ = 256000;
	localparam int SLOW_TICK_HZ = 16000;
	localparam int SLOW_DIV     = FAST_TICK_HZ / SLOW_TICK_HZ;
	localparam logic [24:0] ACC_MOD  = 25'(REF_CLK_HZ);
	localparam logic [24:0] ACC_STEP = 25'(FAST_TICK_HZ);
	localparam logic [3:0]  SUB_LAST = 4'(SLOW_DIV - 1);

	// register indices
	localparam logic [3:0] ADDR_TIMEOUT_RELOAD = 4'h0;
	localparam logic [3:0] ADDR_EVENT_FLAGS    = 4'h1;
	localparam logic [3:0] ADDR_EVENT_ENABLES  = 4'h2;
	localparam logic [3:0] ADDR_PHASE_EVENTS   = 4'h3;
	localparam logic [3:0] ADDR_DELAY_0        = 4'h4;
	localparam logic [3:0] ADDR_DELAY_1        = 4'h5;
	localparam logic [3:0] ADDR_DELAY_2        = 4'h6;
	localparam logic [3:0] ADDR_LINE_CYCLE     = 4'h7;
	localparam logic [3:0] ADDR_DIP_THRESHOLD  = 4'h8;
	localparam logic [3:0] ADDR_DIP_HALF       = 4'h9;
	localparam logic [3:0] ADDR_MEAS_CONFIG    = 4'hA;
	localparam logic [3:0] ADDR_COMP_CONFIG    = 4'hB;
	localparam logic [3:0] ADDR_ACCUM_CONFIG   = 4'hC;

	// field positions
	localparam int EV_TMO_LSB   = 3;
	localparam int EV_DIP       = 16;
	localparam int EV_SEQ       = 19;
	localparam int DIP_PH_LSB   = 12;
	localparam int CYCLE_PHASE_SELECT_LSB   = 0;
	localparam int ANGSEL_LSB   = 9;
	localparam int WIRING_SELECT_LSB   = 4;
	localparam logic [31:0] EV_IMPL = 32'h0009_01F8;

	// values after reset and limits
	localparam logic [15:0] RELOAD_RST  = 16'hFFFF;
	localparam logic [7:0]  HALF_RST    = 8'h01;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [23:0] FULL_SCALE  = 24'h5A7540;
	localparam logic [23:0] VOLT_MIN    = FULL_SCALE / 24'h00000A;

	typedef enum logic [1:0] {PAIR_VI, PAIR_VV, PAIR_II, PAIR_SPARE} pair_sel_e;

	// channel index of start and stop per delay result, entry 0 in the low bits
	localparam logic [2:0][2:0] VV_START = {3'h0, 3'h1, 3'h0};
	localparam logic [2:0][2:0] VV_STOP  = {3'h1, 3'h2, 3'h2};
	localparam logic [2:0] CURR_OFS = 3'h3;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [24:0] acc;
		logic [3:0]  sub;
		logic        fast;
		logic        slow;
	} tick_st_s;

	typedef struct packed {
		logic [15:0] cnt;
		logic        hit;
	} tmo_st_s;

	typedef struct packed {
		logic [31:0]       flags;
		logic [31:0]       mask;
		logic [15:0]       reload;
		logic [2:0][15:0]  delay;
		logic [2:0][15:0]  dcnt;
		logic [2:0]        drun;
		logic [15:0]       period;
		logic [15:0]       pcnt;
		logic              pvalid;
		logic [23:0]       thr;
		logic [7:0]        half;
		logic [1:0]        mcfg;
		pair_sel_e         ccfg;
		logic [1:0]        acfg;
		logic [1:0]        last_ph;
		logic              last_ok;
		logic [2:0]        above;
		logic [2:0][7:0]   hcnt;
		logic [2:0]        dphase;
		logic              irq_n;
		logic [31:0]       rdata;
	} mon_st_s;

	localparam mon_st_s MON_RST = '{reload: RELOAD_RST, half: HALF_RST, ccfg: PAIR_VI,
		irq_n: 1'b1, default: '0};

endpackage : lcqm_pkg

// ==== rtl/tick_divider.sv ====
// fractional divider making the 256 kHz and 16 kHz enable pulses
// assumes the 20 MHz reference clock; ticks jitter by one clock, average exact
module tick_divider (
	input  wire logic ref_clk_in,
	input  wire logic reset_n_in,
	output logic      fast_tick_out,
	output logic      slow_tick_out
);
	import lcqm_pkg::*;

	tick_st_s    st;
	tick_st_s    next_st;
	logic [25:0] sum;

	always_comb begin
		next_st      = st;
		next_st.fast = 1'b0;
		next_st.slow = 1'b0;
		sum          = {1'b0, st.acc} + {1'b0, ACC_STEP};
		if (sum >= {1'b0, ACC_MOD}) begin
			next_st.acc  = 25'(sum - {1'b0, ACC_MOD});
			next_st.fast = 1'b1;
			if (st.sub == SUB_LAST) begin
				next_st.sub  = '0;
				next_st.slow = 1'b1;
			end else begin
				next_st.sub = st.sub + 4'h1;
			end
		end else begin
			next_st.acc = sum[24:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fast_tick_out = st.fast;
	assign slow_tick_out = st.slow;

endmodule : tick_divider

// ==== rtl/crossing_timeout.sv ====
// one zero-crossing timeout counter
// assumes crossing and tick pulses are one cycle wide on the same clock
module crossing_timeout (
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [15:0] reload_in,
	input  wire logic        crossing_in,
	input  wire logic        slow_tick_in,
	output logic             timeout_out
);
	import lcqm_pkg::*;

	tmo_st_s st;
	tmo_st_s next_st;

	always_comb begin
		next_st     = st;
		next_st.hit = 1'b0;
		if (crossing_in) begin
			next_st.cnt = reload_in;
		end else if (slow_tick_in) begin
			if (st.cnt <= 16'h0001) begin
				next_st.hit = 1'b1;
				next_st.cnt = reload_in;
			end else begin
				next_st.cnt = st.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '{cnt: RELOAD_RST, hit: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign timeout_out = st.hit;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	property p_reload;
		crossing_in |=> st.cnt == $past(reload_in);
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded");

	property p_expire;
		(!crossing_in && slow_tick_in && st.cnt == 16'h0001) |=> timeout_out ##1 !timeout_out;
	endproperty
	a_expire: assert property (p_expire) else $error("timeout missed");

	property p_count;
		(!crossing_in && slow_tick_in && st.cnt > 16'h0001) |=> st.cnt == $past(st.cnt) - 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter did not step");

endmodule : crossing_timeout

// ==== rtl/line_cycle_quality_monitor.sv ====
// line cycle quality monitor: crossing timeouts, phase order, delays, period, dips
// assumes crossing pulses and absolute voltages come from dsp logic on ref_clk_in
module line_cycle_quality_monitor (
	input  wire logic              ref_clk_in,
	input  wire logic              reset_n_in,
	input  wire lcqm_pkg::reg_req_s reg_req_in,
	input  wire logic [5:0]        zc_rise_in,
	input  wire logic [5:0]        zc_fall_in,
	input  wire logic [2:0][23:0]  volt_abs_in,
	output logic [31:0]            reg_rdata_out,
	output logic                   interrupt_line_second_n_out
);
	import lcqm_pkg::*;

	mon_st_s     st;
	mon_st_s     next_st;
	logic        fast_tick;
	logic        slow_tick;
	logic [2:0]  amp_ok;
	logic [5:0]  cross_any;
	logic [5:0]  rise_ok;
	logic [5:0]  tmo_hit;
	logic [2:0]  dstart;
	logic [2:0]  dstop;
	logic [31:0] ev_set;
	logic [31:0] ev_clr;
	logic        dip_set;
	logic        seq_fault;
	logic [2:0]  new_dph;
	logic [1:0]  per_ph;
	logic        per_rise;
	logic [8:0]  hplus;
	logic        wr_half;

	tick_divider u_ticks (
		.ref_clk_in    (ref_clk_in),
		.reset_n_in    (reset_n_in),
		.fast_tick_out (fast_tick),
		.slow_tick_out (slow_tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_chan
			if (gi < 3) begin : g_volt
				assign amp_ok[gi]    = volt_abs_in[gi] >= VOLT_MIN;
				assign cross_any[gi] = (zc_rise_in[gi] | zc_fall_in[gi]) & amp_ok[gi];
				assign rise_ok[gi]   = zc_rise_in[gi] & amp_ok[gi];
				always_comb begin
					case (st.ccfg)
						PAIR_VV: begin
							dstart[gi] = rise_ok[VV_START[gi]];
							dstop[gi]  = rise_ok[VV_STOP[gi]];
						end
						PAIR_II: begin
							dstart[gi] = rise_ok[VV_START[gi] + CURR_OFS];
							dstop[gi]  = rise_ok[VV_STOP[gi] + CURR_OFS];
						end
						default: begin
							dstart[gi] = rise_ok[gi];
							dstop[gi]  = rise_ok[gi + 3];
						end
					endcase
				end
			end else begin : g_curr
				// current crossings pass regardless of amplitude
				assign cross_any[gi] = zc_rise_in[gi] | zc_fall_in[gi];
				assign rise_ok[gi]   = zc_rise_in[gi];
			end
			crossing_timeout u_tmo (
				.ref_clk_in   (ref_clk_in),
				.reset_n_in   (reset_n_in),
				.reload_in    (st.reload),
				.crossing_in  (cross_any[gi]),
				.slow_tick_in (slow_tick),
				.timeout_out  (tmo_hit[gi])
			);
		end
	endgenerate

	always_comb begin
		next_st   = st;
		ev_set    = '0;
		ev_clr    = '0;
		dip_set   = 1'b0;
		seq_fault = 1'b0;
		new_dph   = '0;
		hplus     = '0;
		wr_half   = 1'b0;
		per_ph    = (st.mcfg == 2'h3) ? 2'h0 : st.mcfg;
		per_rise  = rise_ok[per_ph];

		ev_set[EV_TMO_LSB +: 6] = tmo_hit;

		for (int p = 2; p >= 0; p--) begin
			if (rise_ok[p]) begin
				next_st.last_ph = 2'(p);
				next_st.last_ok = 1'b1;
			end
		end
		for (int p = 0; p < 3; p++) begin
			if (rise_ok[p] && st.last_ok) begin
				if (2'(p) != ((st.last_ph == 2'h2) ? 2'h0 : st.last_ph + 2'h1)) begin
					seq_fault = 1'b1;
				end
			end
		end
		ev_set[EV_SEQ] = seq_fault;

		for (int i = 0; i < 3; i++) begin
			if (dstart[i]) begin
				next_st.dcnt[i] = '0;
				next_st.drun[i] = 1'b1;
			end else if (dstop[i] && st.drun[i]) begin
				next_st.delay[i] = st.dcnt[i];
				next_st.drun[i]  = 1'b0;
			end else if (fast_tick && st.drun[i] && st.dcnt[i] != COUNT_MAX) begin
				next_st.dcnt[i] = st.dcnt[i] + 16'h0001;
			end
		end

		if (per_rise) begin
			if (st.pvalid) begin
				next_st.period = (st.pcnt == '0) ? '0 : st.pcnt - 16'h0001;
			end
			next_st.pcnt   = '0;
			next_st.pvalid = 1'b1;
		end else if (fast_tick && st.pcnt != COUNT_MAX) begin
			next_st.pcnt = st.pcnt + 16'h0001;
		end

		// half cycles below threshold
		// dip counting uses raw crossings, since a sagged phase may fall under the gate
		for (int p = 0; p < 3; p++) begin
			if (zc_rise_in[p] || zc_fall_in[p]) begin
				next_st.above[p] = 1'b0;
				if (st.above[p]) begin
					next_st.hcnt[p] = '0;
				end else begin
					hplus = {1'b0, st.hcnt[p]} + 9'h001;
					if (hplus >= {1'b0, st.half}) begin
						dip_set         = 1'b1;
						new_dph[p]      = 1'b1;
						next_st.hcnt[p] = '0;
					end else begin
						next_st.hcnt[p] = hplus[7:0];
					end
				end
			end else if (volt_abs_in[p] >= st.thr) begin
				next_st.above[p] = 1'b1;
			end
		end
		ev_set[EV_DIP] = dip_set;
		// register writes
		if (reg_req_in.wr) begin
			if (reg_req_in.addr == ADDR_TIMEOUT_RELOAD) begin
				next_st.reload = reg_req_in.wdata[15:0];
			end else if (reg_req_in.addr == ADDR_EVENT_FLAGS) begin
				ev_clr = reg_req_in.wdata;
			end else if (reg_req_in.addr == ADDR_EVENT_ENABLES) begin
				next_st.mask = reg_req_in.wdata & EV_IMPL;
			end else if (reg_req_in.addr == ADDR_DIP_THRESHOLD) begin
				next_st.thr = reg_req_in.wdata[23:0];
			end else if (reg_req_in.addr == ADDR_DIP_HALF) begin
				next_st.half = reg_req_in.wdata[7:0];
				wr_half      = 1'b1;
			end else if (reg_req_in.addr == ADDR_MEAS_CONFIG) begin
				next_st.mcfg = reg_req_in.wdata[CYCLE_PHASE_SELECT_LSB +: 2];
			end else if (reg_req_in.addr == ADDR_COMP_CONFIG) begin
				next_st.ccfg = pair_sel_e'(reg_req_in.wdata[ANGSEL_LSB +: 2]);
				// a half-done delay would pair the wrong channels
				next_st.drun = '0;
			end else if (reg_req_in.addr == ADDR_ACCUM_CONFIG) begin
				next_st.acfg = reg_req_in.wdata[WIRING_SELECT_LSB +: 2];
			end
		end

		if (wr_half && st.thr != '0) begin
			next_st.hcnt  = '0;
			next_st.above = '0;
		end

		next_st.flags = ((st.flags & ~ev_clr) | ev_set) & EV_IMPL;
		if (dip_set) begin
			next_st.dphase = new_dph;
		end else if (ev_clr[EV_DIP]) begin
			next_st.dphase = '0;
		end

		next_st.irq_n = ~|(next_st.flags & next_st.mask);

		// reads are answered one cycle after the strobe
		if (reg_req_in.rd) begin
			if (reg_req_in.addr == ADDR_TIMEOUT_RELOAD) begin
				next_st.rdata = {16'h0000, st.reload};
			end else if (reg_req_in.addr == ADDR_EVENT_FLAGS) begin
				next_st.rdata = st.flags;
			end else if (reg_req_in.addr == ADDR_EVENT_ENABLES) begin
				next_st.rdata = st.mask;
			end else if (reg_req_in.addr == ADDR_PHASE_EVENTS) begin
				next_st.rdata = 32'(st.dphase) << DIP_PH_LSB;
			end else if (reg_req_in.addr == ADDR_DELAY_0) begin
				next_st.rdata = {16'h0000, st.delay[0]};
			end else if (reg_req_in.addr == ADDR_DELAY_1) begin
				next_st.rdata = {16'h0000, st.delay[1]};
			end else if (reg_req_in.addr == ADDR_DELAY_2) begin
				next_st.rdata = {16'h0000, st.delay[2]};
			end else if (reg_req_in.addr == ADDR_LINE_CYCLE) begin
				next_st.rdata = {16'h0000, st.period};
			end else if (reg_req_in.addr == ADDR_DIP_THRESHOLD) begin
				next_st.rdata = {8'h00, st.thr};
			end else if (reg_req_in.addr == ADDR_DIP_HALF) begin
				next_st.rdata = {24'h000000, st.half};
			end else if (reg_req_in.addr == ADDR_MEAS_CONFIG) begin
				next_st.rdata = 32'(st.mcfg) << CYCLE_PHASE_SELECT_LSB;
			end else if (reg_req_in.addr == ADDR_COMP_CONFIG) begin
				next_st.rdata = 32'(st.ccfg) << ANGSEL_LSB;
			end else if (reg_req_in.addr == ADDR_ACCUM_CONFIG) begin
				next_st.rdata = 32'(st.acfg) << WIRING_SELECT_LSB;
			end else begin
				next_st.rdata = '0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= MON_RST;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_out               = st.rdata;
	assign interrupt_line_second_n_out = st.irq_n;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	property p_tmo_irq;
		(|(st.flags[EV_TMO_LSB +: 6] & st.mask[EV_TMO_LSB +: 6])) |-> !interrupt_line_second_n_out;
	endproperty
	a_tmo_irq: assert property (p_tmo_irq) else $error("timeout irq not low");

	property p_w1c;
		(reg_req_in.wr && reg_req_in.addr == ADDR_EVENT_FLAGS && reg_req_in.wdata[EV_DIP]
			&& !dip_set) |=> !st.flags[EV_DIP] && st.dphase == 3'h0;
	endproperty
	a_w1c: assert property (p_w1c) else $error("dip clear failed");

	property p_seq;
		(rise_ok[2] && !rise_ok[1] && !rise_ok[0] && st.last_ok && st.last_ph == 2'h0)
			|=> st.flags[EV_SEQ];
	endproperty
	a_seq: assert property (p_seq) else $error("order fault missed");

	property p_seq_irq;
		(seq_fault && st.mask[EV_SEQ]) |=> !interrupt_line_second_n_out [*2];
	endproperty
	a_seq_irq: assert property (p_seq_irq) else $error("order irq missing");

	property p_delay;
		(st.ccfg == PAIR_VI && st.drun[0] && zc_rise_in[3] && !rise_ok[0])
			|=> st.delay[0] == $past(st.dcnt[0]) && !st.drun[0];
	endproperty
	a_delay: assert property (p_delay) else $error("delay 0 wrong");

	property p_period;
		(per_rise && st.pvalid && st.pcnt != 16'h0000) |=> st.period == $past(st.pcnt) - 16'h0001;
	endproperty
	a_period: assert property (p_period) else $error("period wrong");

	property p_dip;
		dip_set |=> st.flags[EV_DIP] && st.dphase == $past(new_dph) && st.dphase != 3'h0;
	endproperty
	a_dip: assert property (p_dip) else $error("dip flag missing");

	property p_dip_irq;
		(dip_set && st.mask[EV_DIP]) |=> !interrupt_line_second_n_out;
	endproperty
	a_dip_irq: assert property (p_dip_irq) else $error("dip irq late");

	property p_half_wr;
		(reg_req_in.wr && reg_req_in.addr == ADDR_DIP_HALF && st.thr != 24'h000000)
			|=> st.hcnt == '0;
	endproperty
	a_half_wr: assert property (p_half_wr) else $error("dip window not restarted");

	property p_gate;
		(zc_rise_in[0] && volt_abs_in[0] < VOLT_MIN) |-> !rise_ok[0];
	endproperty
	a_gate: assert property (p_gate) else $error("small voltage crossing passed");

	c_seq:    cover property (seq_fault);
	c_dip:    cover property (dip_set && st.mask[EV_DIP]);
	c_period: cover property (per_rise && st.pvalid);
	c_tmo:    cover property (|tmo_hit);

endmodule : line_cycle_quality_monitor

// ==== sim/host_port_model.sv ====
// host side of the register port: strobed writes and reads
// assumes strobes are sampled on the rising edge of ref_clk_in
module host_port_model (
	input  wire logic          ref_clk_in,
	input  wire logic [31:0]   rdata_in,
	output lcqm_pkg::reg_req_s req_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import lcqm_pkg::*;

	initial req_out = '0;

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		if (a == ADDR_DIP_HALF && d == 32'h0) return;
		@(negedge ref_clk_in);
		req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk_in);
		req_out.wr = 1'b0;
		// released data no longer shows the last word
		req_out.wdata = ~req_out.wdata;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(negedge ref_clk_in);
		req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req_out.wdata};
		@(negedge ref_clk_in);
		req_out.rd = 1'b0;
		d = rdata_in;
	endtask : rd

endmodule : host_port_model

// ==== sim/line_cycle_quality_monitor_tb.sv ====
// bench for the line cycle quality monitor, registers reached through the host model
// assumes crossing pulses and voltage levels are driven here on falling edges
module line_cycle_quality_monitor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lcqm_pkg::*;

	localparam logic [23:0] V_OK  = 24'h100000;
	localparam logic [23:0] V_LOW = 24'h010000;
	localparam int          GAP   = 781;

	logic             ref_clk_in;
	logic             reset_n_in;
	reg_req_s         req;
	logic [5:0]       rise;
	logic [5:0]       fall;
	logic [2:0][23:0] vabs;
	logic [31:0]      rdata;
	logic [31:0]      r;
	logic             irq_n;
	int               fail_count;
	int               num_checks;
	int               cycles;
	int               seq [8] = '{0, 1, 2, 0, 1, 2, 0, 2};
	// crossing masks per slot, slot 0 in the low bits
	logic [3:0][5:0]  slots [3] = '{{6'h20, 6'h10, 6'h08, 6'h07},
		{6'h04, 6'h00, 6'h02, 6'h01}, {6'h20, 6'h00, 6'h10, 6'h08}};
	// delay results in slot gaps, result 0 in the low bits
	logic [2:0][1:0]  dexp [3] = '{{2'd3, 2'd2, 2'd1}, {2'd1, 2'd2, 2'd3},
		{2'd1, 2'd2, 2'd3}};

	line_cycle_quality_monitor dut (
		.ref_clk_in                  (ref_clk_in),
		.reset_n_in                  (reset_n_in),
		.reg_req_in                  (req),
		.zc_rise_in                  (rise),
		.zc_fall_in                  (fall),
		.volt_abs_in                 (vabs),
		.reg_rdata_out               (rdata),
		.interrupt_line_second_n_out (irq_n)
	);

	host_port_model host (
		.ref_clk_in (ref_clk_in),
		.rdata_in   (rdata),
		.req_out    (req)
	);

	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// run is about 18k cycles; a hang stops well past that
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			$display("unexpected at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp

	// tick counts jitter by one against the reference clock
	task automatic near(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (!(got === exp || got === exp + 32'h1 || got === exp - 32'h1)) begin
			fail_count++;
			$display("unexpected at %0t: count %h, near %h", $time, got, exp);
		end
	endtask : near

	task automatic chk(input logic [3:0] a, input logic [31:0] exp);
		host.rd(a, r);
		cmp(r, exp);
	endtask : chk

	task automatic irq(input logic exp);
		cmp({31'h0, irq_n}, {31'h0, exp});
	endtask : irq

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : idle

	task automatic pulse(input logic [5:0] rr, input logic [5:0] ff);
		@(negedge ref_clk_in);
		rise = rr;
		fall = ff;
		@(negedge ref_clk_in);
		rise = '0;
		fall = '0;
	endtask : pulse

	initial begin
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		reset_n_in = 1'b0;
		rise = '0;
		fall = '0;
		vabs = {3{V_OK}};
		idle(2);
		reset_n_in = 1'b1;
		irq(1'b1);
		chk(ADDR_TIMEOUT_RELOAD, 32'h0000_FFFF);
		chk(4'hF, 32'h0);
		host.wr(ADDR_DELAY_0, 32'h0000_1234);
		chk(ADDR_DELAY_0, 32'h0);
		host.wr(ADDR_EVENT_ENABLES, 32'hFFFF_FFFF);
		chk(ADDR_EVENT_ENABLES, EV_IMPL);
		host.wr(ADDR_TIMEOUT_RELOAD, 32'h2);
		pulse('0, 6'h3F);
		vabs[1] = V_LOW;
		repeat (8) begin
			idle(500);
			pulse('0, 6'h03);
		end
		vabs[1] = V_OK;
		chk(ADDR_EVENT_FLAGS, 32'h0000_01F0);
		irq(1'b0);
		host.wr(ADDR_TIMEOUT_RELOAD, 32'hFFFF);
		pulse('0, 6'h3F);
		host.wr(ADDR_EVENT_FLAGS, 32'h0000_00F0);
		chk(ADDR_EVENT_FLAGS, 32'h0000_0100);
		irq(1'b0);
		host.wr(ADDR_EVENT_FLAGS, 32'h0000_0100);
		chk(ADDR_EVENT_FLAGS, 32'h0);
		irq(1'b1);
		host.wr(ADDR_ACCUM_CONFIG, 32'h0);
		foreach (seq[i]) begin
			pulse(6'h01 << seq[i], '0);
			idle(10);
			if (i == 5) chk(ADDR_EVENT_FLAGS, 32'h0);
		end
		chk(ADDR_EVENT_FLAGS, 32'h0008_0000);
		irq(1'b0);
		host.wr(ADDR_EVENT_FLAGS, 32'h0008_0000);
		irq(1'b1);
		for (int m = 0; m < 3; m++) begin
			host.wr(ADDR_COMP_CONFIG, 32'(m) << ANGSEL_LSB);
			chk(ADDR_COMP_CONFIG, 32'(m) << ANGSEL_LSB);
			for (int s = 0; s < 4; s++) begin
				pulse(slots[m][s], '0);
				idle(GAP - 2);
			end
			for (int k = 0; k < 3; k++) begin
				host.rd(4'(ADDR_DELAY_0 + k), r);
				near(r, 32'(dexp[m][k]) * 32'd10);
			end
			host.wr(ADDR_EVENT_FLAGS, 32'hFFFF_FFFF);
		end
		host.wr(ADDR_MEAS_CONFIG, 32'h1);
		chk(ADDR_MEAS_CONFIG, 32'h1);
		pulse(6'h02, '0);
		idle(400);
		pulse(6'h01, '0);
		idle(1158);
		pulse(6'h02, '0);
		idle(1560);
		pulse(6'h02, '0);
		host.rd(ADDR_LINE_CYCLE, r);
		near(r, 32'd19);
		host.wr(ADDR_EVENT_FLAGS, 32'hFFFF_FFFF);
		host.wr(ADDR_DIP_THRESHOLD, 32'h0008_0000);
		host.wr(ADDR_DIP_HALF, 32'h2);
		chk(ADDR_DIP_HALF, 32'h2);
		chk(ADDR_DIP_THRESHOLD, 32'h0008_0000);
		for (int p = 1; p < 3; p++) begin
			vabs = {3{V_OK}};
			vabs[p] = V_LOW;
			repeat (2) begin
				pulse(6'h01 << p, '0);
				idle(200);
				pulse('0, 6'h01 << p);
				idle(200);
			end
			chk(ADDR_EVENT_FLAGS, 32'h0001_0000);
			irq(1'b0);
			chk(ADDR_PHASE_EVENTS, 32'h1 << (12 + p));
		end
		host.wr(ADDR_EVENT_FLAGS, 32'h0001_0000);
		chk(ADDR_PHASE_EVENTS, 32'h0);
		chk(ADDR_EVENT_FLAGS, 32'h0);
		irq(1'b1);
		end_of_test();
	end

endmodule : line_cycle_quality_monitor_tb
